// ---- design/fcp_cfg.svh ----
// Constants for the four-channel modulator: offsets, fields, resets, timing
`ifndef FCP_CFG_SVH
`define FCP_CFG_SVH

// ************************************************************
// Geometry
// ************************************************************
`define FCP_CNT_W        10
`define FCP_NCH          4

// ************************************************************
// Register byte offsets
// ************************************************************
`define FCP_OFS_CTRL1    8'h00
`define FCP_OFS_CTRL2    8'h04
`define FCP_OFS_CTRL3    8'h08
`define FCP_OFS_PERIOD   8'h0c
`define FCP_OFS_CMP0     8'h10
`define FCP_CMP_STRIDE   8'h04
`define FCP_OFS_COUNT    8'h20

// ************************************************************
// Field positions
// ************************************************************
`define FCP_C1_RUN       7
`define FCP_C1_LOAD      6
`define FCP_C1_UFLOW     5
`define FCP_C2_SOFT      7
`define FCP_C2_POL       6
`define FCP_C2_BKIE      5
`define FCP_C2_LVL_LO    0
`define FCP_C3_FP_LO     2
`define FCP_C3_BKF       0

// ************************************************************
// Reset values and answers
// ************************************************************
`define FCP_RST_PERIOD   10'h3ff
`define FCP_RST_CMP      10'h000
`define FCP_RST_LVL      4'h0
`define FCP_RESP_OKAY    2'b00
`define FCP_RESP_SLVERR  2'b10

// ************************************************************
// Prescaler terminal counts (divide ratio minus one)
// ************************************************************
`define FCP_PS_W         8
`define FCP_PS_DIV1      8'h00
`define FCP_PS_DIV2      8'h01
`define FCP_PS_DIV4      8'h03
`define FCP_PS_DIV8      8'h07

`endif

// ---- design/fcp_channel.sv ----
// One modulated channel: compares the active value with the counter
`include "fcp_cfg.svh"
module fcp_channel
   import fcp_pkg::*;
   #(parameter int CNT_W = `FCP_CNT_W)
   (
   input  wire logic             ref_clk,
   input  wire logic             nrst,
   input  wire logic             init,
   input  wire logic             initLevel,
   input  wire logic             update,
   input  wire logic [CNT_W-1:0] cnt,
   input  wire logic [CNT_W-1:0] cmp,
   output logic                  level
   );

   logic level_q;   // Held output level
   logic cmpLevel;  // Level the compare asks for now

   // All ones forces low, otherwise low while compare exceeds count
   function automatic logic compLevel(input logic [CNT_W-1:0] c,
                                      input logic [CNT_W-1:0] n);
      if (&c) begin
         return 1'b0;
      end
      return !(c > n);
   endfunction

   assign cmpLevel = compLevel(cmp, cnt); // RL7 RL10
   assign level    = level_q;

   // ************************************************************
   // Output flop
   // ************************************************************
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         level_q <= 1'b0;
      end else if (init) begin
         level_q <= initLevel; // RL2
      end else if (update) begin
         level_q <= cmpLevel; // RL9
      end
   end

endmodule

// ---- design/fcp_pkg.sv ----
// Types shared by the four-channel modulator files
package fcp_pkg;

   // ************************************************************
   // Bus carriers
   // ************************************************************
   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } fcp_axi_req_type;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } fcp_axi_rsp_type;

   // Output pins, one bit per channel
   typedef struct packed {
      logic [3:0] level;
      logic [3:0] oe;
   } fcp_pins_type;

   // Engine states
   typedef enum logic [4:0] {
      ST_INIT  = 5'b00001,
      ST_STOP  = 5'b00010,
      ST_RUN   = 5'b00100,
      ST_BRAKE = 5'b01000,
      ST_ICP   = 5'b10000
   } fcp_state_type;

endpackage

// ---- design/fcp_prescaler.sv ----
// Counter clock prescaler producing one tick per divided period
`include "fcp_cfg.svh"
module fcp_prescaler
   import fcp_pkg::*;
   (
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic       run,
   input  wire logic [1:0] sel,
   output logic            tick
   );

   logic [`FCP_PS_W-1:0] div_q;   // Running divide count
   logic [`FCP_PS_W-1:0] limit;   // Terminal count for this ratio

   // ************************************************************
   // Ratio decode
   // ************************************************************
   assign limit = (sel == 2'h0) ? `FCP_PS_DIV1 :
                  (sel == 2'h1) ? `FCP_PS_DIV2 :
                  (sel == 2'h2) ? `FCP_PS_DIV4 : `FCP_PS_DIV8;
   assign tick  = run && (div_q >= limit);

   // Count only while running, so a restart begins a full period
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         div_q <= '0;
      end else if (!run || tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

endmodule

// ---- design/fcp_top.sv ----
// Four-channel modulator with shared down counter, brake and register slave
//
// Notes on behaviour
// (RL1) Four channels share one counter and period.
// (RL2) Outputs start at the port reset level.
// (RL3) Ten-bit down counter through two-bit prescaler.
// (RL4) Underflow reloads from counter register, period plus one.
// (RL5) Run, load, flag set load period; load clears.
// (RL6) Underflow sets flag; only software clears it.
// (RL7) Output low while compare exceeds counter.
// (RL8) New compares take effect at underflow after load.
// (RL9) High time is period minus compare plus one.
// (RL10) Compare zero stays high, all ones stays low.
// (RL11) Programming mode tri-states pins and stops modulation.
// (RL12) Brake from software bit or brake pin.
// (RL13) Polarity bit selects brake pin active level.
// (RL14) Pin brake clears run and sets brake flag.
// (RL15) Brake flag polled or raises enabled interrupt.
// (RL16) Released brake restores previous output levels.
// (RL17) Short brake pulses also need external interrupt.
// (RL18) Reset level bit: zero low, one high.
// (RL19) Interrupt follows flag and enable until cleared.
// (RL20) Stopped counter holds value; outputs keep levels.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`include "fcp_cfg.svh"
module fcp_top
   import fcp_pkg::*;
   #(parameter int CNT_W = `FCP_CNT_W)
   (
   input  wire logic            ref_clk,
   input  wire logic            nrst,
   input  wire fcp_axi_req_type axiReq,
   output fcp_axi_rsp_type      axiRsp,
   input  wire logic            portResetLevel,
   input  wire logic            icpMode,
   input  wire logic            brakePin,
   output fcp_pins_type         pins,
   output logic                 brakeIrq
   );

   // ************************************************************
   // Elaboration check
   // ************************************************************
   generate
      if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
         $error("Counter width must lie between 2 and 16");
      end
   endgenerate

   // ************************************************************
   // Declarations
   // ************************************************************
   fcp_state_type    state_q;           // Engine state
   fcp_state_type    state_d;           // Next engine state
   logic             run_q;             // Counter run bit
   logic             load_q;            // Load request bit
   logic             uflow_q;           // Underflow flag
   logic             soft_q;            // Software brake
   logic             pol_q;             // Brake pin polarity
   logic             bkie_q;            // Brake interrupt enable
   logic [3:0]       lvl_q;             // Levels shown during brake
   logic [1:0]       fp_q;              // Prescale select
   logic             bkf_q;             // Brake flag
   logic [CNT_W-1:0] period_q;          // Software period value
   logic [CNT_W-1:0] reload_q;          // Counter register
   logic [CNT_W-1:0] cnt_q;             // Down counter
   logic [CNT_W-1:0] cnt_d;             // Next down counter
   logic [CNT_W-1:0] cmpBuf_q [`FCP_NCH]; // Software compares
   logic [CNT_W-1:0] cmpAct_q [`FCP_NCH]; // Active compares
   logic [3:0]       chLevel;           // Channel compare levels
   logic [3:0]       pinLvl_q;          // Registered pin levels
   logic [3:0]       pinOe_q;           // Registered pin enables
   logic             tick;              // Prescaled counter clock
   logic             running;           // Engine in run state
   logic             uflowEv;           // Counter underflow event
   logic             loadNow;           // Reload and compare transfer
   logic             pinBrake;          // Brake pin at active level
   logic             braking;           // Any brake cause active
   logic             wrEn;              // Write taken this edge
   logic             wrC1;              // Write hits control one
   logic             wrC2;              // Write hits control two
   logic             wrC3;              // Write hits control three
   logic             wrPer;             // Write hits period
   logic [3:0]       wrCmp;             // Write hits a compare
   logic [31:0]      c1Word;            // Control one as read
   logic [31:0]      c2Word;            // Control two as read
   logic [31:0]      c3Word;            // Control three as read
   logic [31:0]      wC1;               // Control one after lanes
   logic [31:0]      wC2;               // Control two after lanes
   logic [31:0]      wC3;               // Control three after lanes
   logic [31:0]      wPer;              // Period after lanes
   logic [31:0]      rdWord;            // Read mux result
   logic             rdHit;             // Read address mapped
   logic             bvalid_q;          // Write response pending
   logic [1:0]       bresp_q;           // Write response code
   logic             rvalid_q;          // Read data pending
   logic [31:0]      rdata_q;           // Read data
   logic [1:0]       rresp_q;           // Read response code

   // ************************************************************
   // Helper functions
   // ************************************************************
   // Applies byte strobes of a write onto the current word
   function automatic logic [31:0] mergeLanes(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return res;
   endfunction

   // Byte address of a compare register
   function automatic logic [7:0] cmpAddr(input int idx);
      return 8'(`FCP_OFS_CMP0 + `FCP_CMP_STRIDE * idx);
   endfunction

   // Widens a counter-sized value to a bus word
   function automatic logic [31:0] widen(input logic [CNT_W-1:0] v);
      return {{(32-CNT_W){1'b0}}, v};
   endfunction

   // ************************************************************
   // Register views and write decode
   // ************************************************************
   always_comb begin
      c1Word = '0;
      c1Word[`FCP_C1_RUN]   = run_q;
      c1Word[`FCP_C1_LOAD]  = load_q;
      c1Word[`FCP_C1_UFLOW] = uflow_q;
      c2Word = '0;
      c2Word[`FCP_C2_SOFT]  = soft_q;
      c2Word[`FCP_C2_POL]   = pol_q;
      c2Word[`FCP_C2_BKIE]  = bkie_q;
      c2Word[`FCP_C2_LVL_LO +: 4] = lvl_q;
      c3Word = '0;
      c3Word[`FCP_C3_FP_LO +: 2] = fp_q;
      c3Word[`FCP_C3_BKF]   = bkf_q;
   end

   assign wrEn  = axiReq.awvalid && axiReq.wvalid && !bvalid_q;
   assign wrC1  = wrEn && (axiReq.awaddr == `FCP_OFS_CTRL1);
   assign wrC2  = wrEn && (axiReq.awaddr == `FCP_OFS_CTRL2);
   assign wrC3  = wrEn && (axiReq.awaddr == `FCP_OFS_CTRL3);
   assign wrPer = wrEn && (axiReq.awaddr == `FCP_OFS_PERIOD);
   assign wC1   = mergeLanes(c1Word, axiReq.wdata, axiReq.wstrb);
   assign wC2   = mergeLanes(c2Word, axiReq.wdata, axiReq.wstrb);
   assign wC3   = mergeLanes(c3Word, axiReq.wdata, axiReq.wstrb);
   assign wPer  = mergeLanes(widen(period_q), axiReq.wdata, axiReq.wstrb);

   // ************************************************************
   // Engine decode
   // ************************************************************
   assign running  = (state_q == ST_RUN);
   assign uflowEv  = running && tick && (cnt_q == '0);
   assign loadNow  = run_q && load_q && (uflow_q || uflowEv); // RL5 RL8
   assign pinBrake = pol_q ? brakePin : !brakePin; // RL13
   assign braking  = soft_q || pinBrake; // RL12
   assign brakeIrq = bkf_q && bkie_q; // RL15 RL19

   // Next counter value; holds while neither ticking nor loading
   assign cnt_d = loadNow ? period_q : // RL5
                  uflowEv ? reload_q : // RL4
                  (running && tick) ? cnt_q - 1'b1 : cnt_q; // RL3 RL20

   // Next state: programming mode outranks brake, brake outranks run
   always_comb begin
      if (icpMode) begin
         state_d = ST_ICP; // RL11
      end else if (braking) begin
         state_d = ST_BRAKE;
      end else if (run_q) begin
         state_d = ST_RUN;
      end else begin
         state_d = ST_STOP;
      end
   end

   // ************************************************************
   // Prescaler and channels
   // ************************************************************
   fcp_prescaler u_prescaler (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .run     (running),
      .sel     (fp_q),
      .tick    (tick)
   );

   generate
      for (genvar i = 0; i < `FCP_NCH; i++) begin : g_ch
         assign wrCmp[i] = wrEn && (axiReq.awaddr == cmpAddr(i));

         // Software compare buffer, byte lanes honoured
         always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
               cmpBuf_q[i] <= `FCP_RST_CMP;
            end else if (wrCmp[i]) begin
               cmpBuf_q[i] <= CNT_W'(mergeLanes(widen(cmpBuf_q[i]),
                                     axiReq.wdata, axiReq.wstrb));
            end
         end

         // Active compare moves only on a load transfer
         always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
               cmpAct_q[i] <= `FCP_RST_CMP;
            end else if (loadNow) begin
               cmpAct_q[i] <= cmpBuf_q[i]; // RL8
            end
         end

         fcp_channel #(.CNT_W(CNT_W)) u_channel (
            .ref_clk   (ref_clk),
            .nrst      (nrst),
            .init      (state_q == ST_INIT),
            .initLevel (portResetLevel), // RL18
            .update    (running),
            .cnt       (cnt_q),
            .cmp       (cmpAct_q[i]),
            .level     (chLevel[i])
         ); // RL1
      end
   endgenerate

   // ************************************************************
   // Engine registers
   // ************************************************************
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_q  <= ST_INIT;
         cnt_q    <= '0;
         reload_q <= `FCP_RST_PERIOD;
      end else begin
         state_q  <= state_d;
         cnt_q    <= cnt_d;
         reload_q <= loadNow ? period_q : reload_q; // RL5
      end
   end

   // Pins: brake shows its levels, release shows held channel levels
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pinLvl_q <= '0;
         pinOe_q  <= '0;
      end else begin
         pinLvl_q <= (state_d == ST_BRAKE) ? lvl_q : chLevel; // RL16
         pinOe_q  <= (state_d == ST_ICP) ? 4'h0 : 4'hf; // RL11
      end
   end

   assign pins.level = pinLvl_q;
   assign pins.oe    = pinOe_q;

   // ************************************************************
   // Control registers
   // ************************************************************
   // Run, load and underflow flag; hardware events win over clears
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         run_q   <= 1'b0;
         load_q  <= 1'b0;
         uflow_q <= 1'b0;
      end else begin
         run_q   <= pinBrake ? 1'b0 : (wrC1 ? wC1[`FCP_C1_RUN] : run_q); // RL14
         load_q  <= (wrC1 && wC1[`FCP_C1_LOAD]) ? 1'b1 :
                    loadNow ? 1'b0 : load_q; // RL5
         uflow_q <= uflowEv ||
                    (wrC1 ? (uflow_q && wC1[`FCP_C1_UFLOW]) : uflow_q); // RL6
      end
   end

   // Brake controls and prescale select
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         soft_q <= 1'b0;
         pol_q  <= 1'b0;
         bkie_q <= 1'b0;
         lvl_q  <= `FCP_RST_LVL;
         fp_q   <= 2'h0;
      end else begin
         if (wrC2) begin
            soft_q <= wC2[`FCP_C2_SOFT];
            pol_q  <= wC2[`FCP_C2_POL];
            bkie_q <= wC2[`FCP_C2_BKIE];
            lvl_q  <= wC2[`FCP_C2_LVL_LO +: 4];
         end
         if (wrC3) begin
            fp_q <= wC3[`FCP_C3_FP_LO +: 2]; // RL3
         end
      end
   end

   // Brake flag: pin sets it, software writes zero to clear
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         bkf_q <= 1'b0;
      end else begin
         bkf_q <= pinBrake || (wrC3 ? (bkf_q && wC3[`FCP_C3_BKF]) : bkf_q); // RL14
      end
   end

   // Period: lane one holds the high bits, lane zero the low byte
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         period_q <= `FCP_RST_PERIOD;
      end else if (wrPer) begin
         period_q <= wPer[CNT_W-1:0]; // RL4
      end
   end

   // ************************************************************
   // Read mux
   // ************************************************************
   always_comb begin
      rdHit  = 1'b1;
      rdWord = '0;
      case (axiReq.araddr)
         `FCP_OFS_CTRL1:  rdWord = c1Word;
         `FCP_OFS_CTRL2:  rdWord = c2Word;
         `FCP_OFS_CTRL3:  rdWord = c3Word;
         `FCP_OFS_PERIOD: rdWord = widen(period_q);
         `FCP_OFS_COUNT:  rdWord = widen(cnt_q);
         cmpAddr(0):      rdWord = widen(cmpBuf_q[0]);
         cmpAddr(1):      rdWord = widen(cmpBuf_q[1]);
         cmpAddr(2):      rdWord = widen(cmpBuf_q[2]);
         cmpAddr(3):      rdWord = widen(cmpBuf_q[3]);
         default:         rdHit  = 1'b0;
      endcase
   end

   // ************************************************************
   // Bus responses
   // ************************************************************
   // Write answer one edge after both channels are taken together
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `FCP_RESP_OKAY;
      end else if (wrEn) begin
         bvalid_q <= 1'b1;
         bresp_q  <= (wrC1 || wrC2 || wrC3 || wrPer || (|wrCmp)) ?
                     `FCP_RESP_OKAY : `FCP_RESP_SLVERR;
      end else if (axiReq.bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Read answer one edge after the address is taken
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= `FCP_RESP_OKAY;
      end else if (axiReq.arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rdWord;
         rresp_q  <= rdHit ? `FCP_RESP_OKAY : `FCP_RESP_SLVERR;
      end else if (axiReq.rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign axiRsp.awready = wrEn;
   assign axiRsp.wready  = wrEn;
   assign axiRsp.bvalid  = bvalid_q;
   assign axiRsp.bresp   = bresp_q;
   assign axiRsp.arready = !rvalid_q;
   assign axiRsp.rvalid  = rvalid_q;
   assign axiRsp.rdata   = rdata_q;
   assign axiRsp.rresp   = rresp_q;

endmodule

// ---- verif/fcp_load_model.sv ----
// Loads on the four pads and the driver of the brake line
module fcp_load_model
   import fcp_pkg::*;
   (
   input  wire logic         ref_clk,
   input  wire fcp_pins_type pins,
   input  wire logic         brakeReq,
   input  wire logic         activeHigh,
   output logic [3:0]        padLevel,
   output logic              brakePin
   );
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] lastLevel = 4'h0;   // Last level seen on each pad
   // No pull on the pads, so a released pad toggles instead of keeping a value
   always @(posedge ref_clk) lastLevel <= padLevel;
   assign padLevel = (pins.oe & pins.level) | (~pins.oe & ~lastLevel);
   // The same brake line could also feed an external interrupt input
   assign brakePin = activeHigh ? brakeReq : !brakeReq;
endmodule

// ---- verif/fcp_top_chk.sv ----
// Port checker for the four-channel modulator
module fcp_top_chk
   import fcp_pkg::*;
   #(parameter int CNT_W = 10)
   (
   input wire logic            ref_clk,
   input wire logic            nrst,
   input wire fcp_axi_req_type axiReq,
   input wire fcp_axi_rsp_type axiRsp,
   input wire logic            portResetLevel,
   input wire logic            icpMode,
   input wire logic            brakePin,
   input wire fcp_pins_type    pins,
   input wire logic            brakeIrq
   );
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // Write channels are taken together
   a_aw_joined: assert property (axiRsp.awready == (axiReq.awvalid && axiReq.wvalid
      && !axiRsp.bvalid)) else $error("write ready not joined");
   a_b_follows: assert property (axiRsp.awready |=> axiRsp.bvalid)
      else $error("write answer late");
   a_b_holds: assert property (axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid
      && $stable(axiRsp.bresp)) else $error("write answer dropped");
   a_ar_free: assert property (axiRsp.arready == !axiRsp.rvalid)
      else $error("read ready wrong");
   a_r_follows: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
      else $error("read answer late");
   a_r_holds: assert property (axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid
      && $stable(axiRsp.rdata)) else $error("read answer dropped");
   // Programming mode floats every pad
   a_icp_floats: assert property (icpMode [*3] |-> pins.oe == 4'h0)
      else $error("pads driven in programming mode");
   a_pads_drive: assert property (!icpMode [*3] |-> pins.oe == 4'hf)
      else $error("pads not driven");
endmodule
bind fcp_top fcp_top_chk #(.CNT_W(CNT_W)) chk_u (.ref_clk(ref_clk), .nrst(nrst),
   .axiReq(axiReq), .axiRsp(axiRsp), .portResetLevel(portResetLevel),
   .icpMode(icpMode), .brakePin(brakePin), .pins(pins), .brakeIrq(brakeIrq));

// ---- verif/test_four_channel_pwm_with_brake.sv ----
// Self-checking bench for the four-channel modulator
module test_four_channel_pwm_with_brake
   import fcp_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic [1:0] s;} fcp_row_type;
   logic            ref_clk = 1'b0;
   logic            nrst = 1'b0;
   fcp_axi_req_type axiReq = '0;
   fcp_axi_rsp_type axiRsp;
   logic            portResetLevel = 1'b1;
   logic            icpMode = 1'b0;
   logic            brakeReq = 1'b0;
   logic            brakePin;
   fcp_pins_type    pins;
   logic            brakeIrq;
   logic [3:0]      padLevel;
   logic [31:0]     rdData;
   logic [31:0]     held;
   logic [1:0]      rsp;
   int              bad_count = 0;
   int              cmp_count = 0;
   int              cycles = 0;
   int              rises;
   int              highs [4];
   int              expHigh [4] = '{40, 20, 10, 0};
   // Compare buffers, period with upper bits, unmapped place
   fcp_row_type     rows [6] = '{'{8'h10, 32'h0, 32'h0, 2'b00},
      '{8'h14, 32'h2, 32'h2, 2'b00}, '{8'h18, 32'h3, 32'h3, 2'b00},
      '{8'h1c, 32'h3ff, 32'h3ff, 2'b00}, '{8'h0c, 32'hfffffc03, 32'h3, 2'b00},
      '{8'h24, 32'h1, 32'h0, 2'b10}};
   always #2 ref_clk = ~ref_clk;
   fcp_top #(.CNT_W(10)) dut_u (.ref_clk(ref_clk), .nrst(nrst), .axiReq(axiReq),
      .axiRsp(axiRsp), .portResetLevel(portResetLevel), .icpMode(icpMode),
      .brakePin(brakePin), .pins(pins), .brakeIrq(brakeIrq));
   fcp_load_model load_u (.ref_clk(ref_clk), .pins(pins), .brakeReq(brakeReq),
      .activeHigh(1'b0), .padLevel(padLevel), .brakePin(brakePin));
   task automatic summarize();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         bad_count++;
         summarize();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] s);
      @(posedge ref_clk);
      axiReq <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hf,
         bready: 1'b1, default: '0};
      do @(posedge ref_clk); while (axiRsp.awready !== 1'b1);
      {axiReq.awvalid, axiReq.wvalid} <= 2'b00;
      do @(posedge ref_clk); while (axiRsp.bvalid !== 1'b1);
      s = axiRsp.bresp;
      axiReq.bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
      @(posedge ref_clk);
      axiReq <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
      do @(posedge ref_clk); while (axiRsp.arready !== 1'b1);
      axiReq.arvalid <= 1'b0;
      do @(posedge ref_clk); while (axiRsp.rvalid !== 1'b1);
      d = axiRsp.rdata;
      s = axiRsp.rresp;
      axiReq.rready <= 1'b0;
   endtask
   // Count high cycles per pad and rising edges of pad one
   task automatic measure(input int n);
      logic [3:0] prev = padLevel;
      rises = 0;
      highs = '{0, 0, 0, 0};
      repeat (n) begin
         @(posedge ref_clk);
         for (int i = 0; i < 4; i++) highs[i] += padLevel[i];
         rises += int'(padLevel[1] && !prev[1]);
         prev = padLevel;
      end
   endtask
   initial begin
      for (int k = 1; k >= 0; k--) begin
         nrst <= 1'b0;
         portResetLevel <= k[0];
         repeat (20) @(posedge ref_clk);
         nrst <= 1'b1;
         repeat (3) @(posedge ref_clk);
         chk("reset level", {28'h0, {4{k[0]}}}, {28'h0, pins.level});
      end
      rd(8'h0c, rdData, rsp);
      chk("period reset", 32'h3ff, rdData);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w, rsp);
         chk("write resp", 32'(rows[i].s), 32'(rsp));
         rd(rows[i].a, rdData, rsp);
         chk("read data", rows[i].r, rdData);
         chk("read resp", 32'(rows[i].s), 32'(rsp));
      end
      wr(8'h00, 32'hc0, rsp);
      do rd(8'h00, rdData, rsp); while (rdData[5] !== 1'b1);
      rd(8'h00, rdData, rsp);
      chk("control one", 32'ha0, rdData);
      measure(40);
      foreach (highs[i]) chk("high time", expHigh[i], highs[i]);
      for (int p = 0; p < 4; p++) begin
         wr(8'h08, p << 2, rsp);
         measure(32);
         measure(64);
         chk("edges", 16 >> p, rises);
      end
      wr(8'h00, 32'h20, rsp);
      rd(8'h20, held, rsp);
      rd(8'h00, rdData, rsp);
      chk("flag kept", 32'h20, rdData);
      rd(8'h20, rdData, rsp);
      chk("held count", held, rdData);
      rdData = {28'h0, padLevel};
      wr(8'h04, 32'h8a, rsp);
      measure(4);
      chk("soft brake", 32'ha, {28'h0, padLevel});
      wr(8'h04, 32'h25, rsp);
      wr(8'h00, 32'h80, rsp);
      chk("released", rdData, {28'h0, padLevel});
      brakeReq <= 1'b1;
      measure(4);
      chk("pin brake", 32'h5, {28'h0, padLevel});
      chk("irq on", 32'h1, {31'h0, brakeIrq});
      rd(8'h00, rdData, rsp);
      chk("run bit", 32'h0, {31'h0, rdData[7]});
      rd(8'h08, rdData, rsp);
      chk("brake flag", 32'h0d, rdData);
      brakeReq <= 1'b0;
      wr(8'h08, 32'h0c, rsp);
      chk("irq off", 32'h0, {31'h0, brakeIrq});
      wr(8'h04, 32'h65, rsp);
      icpMode <= 1'b1;
      measure(4);
      chk("float", 32'h0, {28'h0, pins.oe});
      chk("high polarity", 32'h1, {31'h0, brakeIrq});
      icpMode <= 1'b0;
      measure(4);
      chk("drive", 32'hf, {28'h0, pins.oe});
      summarize();
   end
endmodule
